// *** test/test_eri_irq.sv ***
// Self-checking bench for the signalling and zero-run interrupt block
`timescale 1ns/1ps
`default_nettype none
module test_eri_irq
  import eri_pkg::*;
;
  logic          clk;
  logic          rst_n;
  logic          ce;
  logic          psel;
  logic          penable;
  logic          pwrite;
  logic [17:0]   paddr;
  logic [31:0]   pwdata;
  logic [31:0]   prdata;
  logic          pready;
  logic          pslverr;
  logic          sa7_bit;
  logic          sa7_strobe;
  logic          zero_run;
  eri_event_type evt;
  logic          sa7_zero;
  logic          irq;
  logic [31:0]   rd_data;
  logic          rd_err;
  int            err_total;
  int            checks_done;
  int            lim;
  int            sb[4] = '{ERI_BIT_TX_START, ERI_BIT_TX_END, ERI_BIT_RX_START, ERI_BIT_RX_END};
  logic [9:0]    em[4] = '{10'h004, 10'h002, 10'h001, 10'h008};

  eri_irq DUT (
    .CLK_SYS_I       (clk),
    .RESETN_I        (rst_n),
    .CE_I            (ce),
    .PSEL_I          (psel),
    .PENABLE_I       (penable),
    .PWRITE_I        (pwrite),
    .PADDR_I         (paddr),
    .PWDATA_I        (pwdata),
    .PRDATA_O        (prdata),
    .PREADY_O        (pready),
    .PSLVERR_O       (pslverr),
    .SA7_BIT_PIN_I   (sa7_bit),
    .SA7_STROBE_PIN_I(sa7_strobe),
    .ZERO_RUN_PIN_I  (zero_run),
    .EVT_I           (evt),
    .SA7_ZERO_O      (sa7_zero),
    .IRQ_O           (irq)
  );

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Slave latency is not assumed: wait for pready under a bound
  task automatic apb(input logic wr, input logic [17:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 50)
    begin
      n++;
      @(posedge clk);
    end
    check("pready wait", 32'h0000_0000, {31'b0, n == 50});
    rd_data = prdata;
    rd_err  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rdchk(input logic [17:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0000_0000);
    check(what, exp, rd_data);
  endtask

  // One-cycle event pulses with a gap so each is a separate event
  task automatic pulse(input logic [9:0] m, input int k);
    repeat (k)
    begin
      evt <= eri_event_type'(m);
      @(posedge clk);
      evt <= '0;
      @(posedge clk);
    end
  endtask

  // Bit is settled well before the strobe edge, both held long enough for the synchroniser
  task automatic sa7_obs(input logic b);
    sa7_bit <= b;
    repeat (6) @(posedge clk);
    sa7_strobe <= ~sa7_strobe;
    repeat (12) @(posedge clk);
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    err_total++;
    final_report();
  end

  initial
  begin
    rst_n = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    sa7_bit = 1'b1;
    sa7_strobe = 1'b0;
    zero_run = 1'b0;
    evt = '0;
    err_total = 0;
    checks_done = 0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    check("irq after reset", 32'h0000_0000, {31'b0, irq});
    rdchk(ERI_ADDR_SIG_STATUS, 32'h0000_0000, "sig status reset");
    rdchk(ERI_ADDR_SIG_ENABLE, 32'h0000_0000, "sig enable reset");
    rdchk(ERI_ADDR_ZR_ENABLE, 32'h0000_0000, "zr enable reset");
    rdchk(ERI_ADDR_ZR_STATUS, 32'h0000_0000, "zr status reset");
    check("mapped err", 32'h0000_0000, {31'b0, rd_err});
    rdchk(ERI_ADDR_ZR_STATUS + 18'h0_0004, 32'h0000_0000, "unmapped data");
    check("unmapped err", 32'h0000_0001, {31'b0, rd_err});
    apb(1'b1, ERI_ADDR_SIG_ENABLE, 32'hFFFF_FFFF);
    rdchk(ERI_ADDR_SIG_ENABLE, 32'h0000_003F, "sig enable rw");
    apb(1'b1, ERI_ADDR_ZR_ENABLE, 32'h0000_0083);
    rdchk(ERI_ADDR_ZR_ENABLE, 32'h0000_0083, "zr enable rw");
    $display("test registers done");
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, ERI_ADDR_SIG_ENABLE, {24'h0, ERI_SIG_MASK} & ~(32'h0000_0001 << sb[i]));
      pulse(em[i], 1);
      repeat (2) @(posedge clk);
      check("irq masked", 32'h0000_0000, {31'b0, irq});
      apb(1'b1, ERI_ADDR_SIG_ENABLE, 32'h0000_0001 << sb[i]);
      repeat (2) @(posedge clk);
      check("irq enabled", 32'h0000_0001, {31'b0, irq});
      rdchk(ERI_ADDR_SIG_STATUS, 32'h0000_0001 << sb[i], "transfer flag");
      repeat (2) @(posedge clk);
      check("irq cleared", 32'h0000_0000, {31'b0, irq});
      rdchk(ERI_ADDR_SIG_STATUS, 32'h0000_0000, "flag cleared");
    end
    $display("test transfer flags done");
    // An event while the clock enable is low must leave no trace
    ce <= 1'b0;
    pulse(em[3], 1);
    ce <= 1'b1;
    check("irq frozen", 32'h0000_0000, {31'b0, irq});
    rdchk(ERI_ADDR_SIG_STATUS, 32'h0000_0000, "frozen by ce");
    $display("test clock enable done");
    for (int th = 0; th < 2; th++)
    begin
      lim = th ? int'(ERI_CRC_THRESH_HI) : int'(ERI_CRC_THRESH_LO);
      apb(1'b1, ERI_ADDR_ZR_ENABLE, {24'h0, th[0], 7'h00});
      apb(1'b1, ERI_ADDR_SIG_ENABLE, 32'h0000_0001 << ERI_BIT_CRC_FAIL);
      pulse(10'h040, 1);
      pulse(10'h060, lim - 1);
      pulse(10'h040, 1);
      pulse(10'h060, lim - 1);
      rdchk(ERI_ADDR_SIG_STATUS, 32'h0000_0000, "crc below threshold");
      check("crc irq low", 32'h0000_0000, {31'b0, irq});
      pulse(10'h060, 1);
      repeat (2) @(posedge clk);
      check("crc irq high", 32'h0000_0001, {31'b0, irq});
      rdchk(ERI_ADDR_SIG_STATUS, 32'h0000_0001 << ERI_BIT_CRC_FAIL, "crc fail");
    end
    $display("test crc threshold done");
    apb(1'b1, ERI_ADDR_SIG_ENABLE, 32'h0000_0001 << ERI_BIT_OVERSIZE);
    pulse(10'h001, 1);
    pulse(10'h010, int'(ERI_OVERSIZE_BYTES));
    rdchk(ERI_ADDR_SIG_STATUS, 32'h0000_0001 << ERI_BIT_RX_START, "at size limit");
    check("oversize irq low", 32'h0000_0000, {31'b0, irq});
    pulse(10'h010, 1);
    repeat (2) @(posedge clk);
    check("oversize irq", 32'h0000_0001, {31'b0, irq});
    rdchk(ERI_ADDR_SIG_STATUS, 32'h0000_0001 << ERI_BIT_OVERSIZE, "oversize");
    $display("test oversize done");
    apb(1'b1, ERI_ADDR_ZR_ENABLE, 32'h0000_0001 << ERI_BIT_ZERO_RUN);
    zero_run <= 1'b1;
    repeat (10) @(posedge clk);
    check("zero run irq", 32'h0000_0001, {31'b0, irq});
    rdchk(ERI_ADDR_ZR_STATUS, 32'h0000_0001 << ERI_BIT_ZERO_RUN, "zero run set");
    zero_run <= 1'b0;
    // The synchronised fall lands on this read's access edge; the event must survive it
    repeat (3) @(posedge clk);
    rdchk(ERI_ADDR_ZR_STATUS, 32'h0000_0000, "zr read race");
    rdchk(ERI_ADDR_ZR_STATUS, 32'h0000_0001 << ERI_BIT_ZERO_RUN, "zero run clr");
    rdchk(ERI_ADDR_ZR_STATUS, 32'h0000_0000, "zr status read");
    $display("test zero run done");
    apb(1'b1, ERI_ADDR_ZR_ENABLE, 32'h0000_0001 << ERI_BIT_SA7);
    sa7_obs(1'b0);
    rdchk(ERI_ADDR_ZR_STATUS, 32'h0000_0000, "sa7 one zero");
    sa7_obs(1'b0);
    check("sa7 zero state", 32'h0000_0001, {31'b0, sa7_zero});
    check("sa7 irq", 32'h0000_0001, {31'b0, irq});
    rdchk(ERI_ADDR_ZR_STATUS, 32'h0000_0001 << ERI_BIT_SA7, "sa7 declared");
    sa7_obs(1'b1);
    rdchk(ERI_ADDR_ZR_STATUS, 32'h0000_0000, "sa7 still zero");
    sa7_obs(1'b1);
    check("sa7 released", 32'h0000_0000, {31'b0, sa7_zero});
    rdchk(ERI_ADDR_ZR_STATUS, 32'h0000_0001 << ERI_BIT_SA7, "sa7 ended");
    $display("test sa7 done");
    final_report();
  end
endmodule // test_eri_irq
`default_nettype wire

// *** verilog/eri_irq.sv ***
// Signalling and zero-run interrupt flags, enables and APB register port
//
// Notes on behaviour
// R1 - Sa7 change enabled: interrupt when Sa7 zero in two of three observations.
// R2 - Sa7 change enabled: interrupt also when Sa7-zero declaration ends.
// R3 - Zero-run change enabled: interrupt when excessive-zero condition declared.
// R4 - Zero-run change enabled: interrupt when excessive-zero condition removed.
// R5 - Sa7 and zero-run enables read/write; 0 blocks, 1 permits; reset 0.
// R6 - Set CRC failure flag when bad-CRC counter reaches threshold.
// R7 - Failure threshold selectable: 32 or 64 consecutive bad-CRC frames.
// R8 - Oversize interrupt when received message exceeds 276 bytes.
// R9 - Signalling flags set by events, cleared by read, reset to 0.
// R10 - CRC failure enable read/write, reset 0; 1 allows interrupt.
// R11 - Oversize enable read/write, reset 0; 1 allows interrupt.
// R12 - Status bit 5 flags tx unit start, bit 3 tx end; read clears.
// R13 - Status bit 4 flags rx message start, bit 2 rx end; read clears.
// R14 - Enable register has enables for four transfer flags at same bits.
// R15 - Sa7 and zero-run events latched at bits 1 and 0, read clears.
// R16 - Interrupt high while any flag and its enable are both set.
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module eri_irq
  import eri_pkg::*;
(
  input  wire logic          CLK_SYS_I,       // 200 MHz system clock
  input  wire logic          RESETN_I,        // Synchronous reset, active low
  input  wire logic          CE_I,            // Clock enable, freezes all state when low
  input  wire logic          PSEL_I,          // APB select
  input  wire logic          PENABLE_I,       // APB enable
  input  wire logic          PWRITE_I,        // APB direction, high for write
  input  wire logic [17:0]   PADDR_I,         // APB byte address
  input  wire logic [31:0]   PWDATA_I,        // APB write data
  output logic      [31:0]   PRDATA_O,        // APB read data, registered
  output logic               PREADY_O,        // APB ready, registered
  output logic               PSLVERR_O,       // APB error on unmapped address
  input  wire logic          SA7_BIT_PIN_I,   // Received Sa7 bit, from line domain
  input  wire logic          SA7_STROBE_PIN_I,// Toggles once per new Sa7 observation
  input  wire logic          ZERO_RUN_PIN_I,  // Excessive-zero state, from line domain
  input  wire eri_event_type EVT_I,           // Same-clock events from signalling engine
  output logic               SA7_ZERO_O,      // Current Sa7-zero declaration
  output logic               IRQ_O            // Interrupt, active high level
);

  logic       sa7_bit_s;
  logic       sa7_tgl_s;
  logic       zr_s;
  logic       sa7_tgl_prev_q;
  logic [2:0] sa7_hist_q;
  logic       sa7_zero_q;
  logic       zr_prev_q;
  logic [6:0] crc_cnt_q;
  logic [8:0] rx_len_q;
  logic       rx_over_q;
  logic [7:0] sig_status_q;
  logic [7:0] sig_enable_q;
  logic [7:0] zr_status_q;
  logic [7:0] zr_enable_q;
  logic       thresh_hi_q;
  logic [7:0] sig_set;
  logic [7:0] zr_set;
  logic       sa7_obs;
  logic       sa7_zero_d;
  logic       crc_hit;
  logic       acc;
  logic       rd_sig;
  logic       rd_zr;
  logic       mapped;

  eri_sync u_sync_bit (
    .clk_i   (CLK_SYS_I),
    .rst_n_i (RESETN_I),
    .ce_i    (CE_I),
    .d_i     (SA7_BIT_PIN_I),
    .q_o     (sa7_bit_s)
  );

  eri_sync u_sync_tgl (
    .clk_i   (CLK_SYS_I),
    .rst_n_i (RESETN_I),
    .ce_i    (CE_I),
    .d_i     (SA7_STROBE_PIN_I),
    .q_o     (sa7_tgl_s)
  );

  eri_sync u_sync_zr (
    .clk_i   (CLK_SYS_I),
    .rst_n_i (RESETN_I),
    .ce_i    (CE_I),
    .d_i     (ZERO_RUN_PIN_I),
    .q_o     (zr_s)
  );

  // Access phase is taken once; PREADY_O answers on the next cycle
  assign acc    = PSEL_I && PENABLE_I && !PREADY_O;
  assign mapped = (PADDR_I == ERI_ADDR_SIG_STATUS) || (PADDR_I == ERI_ADDR_SIG_ENABLE) ||
                  (PADDR_I == ERI_ADDR_ZR_ENABLE) || (PADDR_I == ERI_ADDR_ZR_STATUS);
  assign rd_sig = acc && !PWRITE_I && (PADDR_I == ERI_ADDR_SIG_STATUS);
  assign rd_zr  = acc && !PWRITE_I && (PADDR_I == ERI_ADDR_ZR_STATUS);

  // Sa7 majority vote over the last three observations
  assign sa7_obs    = sa7_tgl_s != sa7_tgl_prev_q;
  assign sa7_zero_d = ({1'b0, ~sa7_hist_q[0]} + {1'b0, ~sa7_hist_q[1]}
                       + {1'b0, ~sa7_hist_q[2]}) >= 2'(ERI_VOTE_MIN);

  // R7 threshold select
  assign crc_hit = EVT_I.crc_frame_done && EVT_I.crc_frame_bad &&
                   ((crc_cnt_q + 7'd1) == (thresh_hi_q ? ERI_CRC_THRESH_HI : ERI_CRC_THRESH_LO));

  always_comb
  begin
    zr_set = 8'h00;
    // R1 R2 Sa7 declaration change
    zr_set[ERI_BIT_SA7]      = sa7_zero_d != sa7_zero_q;
    // R3 R4 zero-run either edge
    zr_set[ERI_BIT_ZERO_RUN] = zr_s != zr_prev_q;
    sig_set = 8'h00;
    // R12 R13 transfer events
    sig_set[ERI_BIT_TX_START] = EVT_I.tx_unit_start;
    sig_set[ERI_BIT_RX_START] = EVT_I.rx_msg_start;
    sig_set[ERI_BIT_TX_END]   = EVT_I.tx_unit_end;
    sig_set[ERI_BIT_RX_END]   = EVT_I.rx_msg_end;
    // R6 failure event
    sig_set[ERI_BIT_CRC_FAIL] = crc_hit;
    // R8 oversize event, once per message
    sig_set[ERI_BIT_OVERSIZE] = EVT_I.rx_byte && !rx_over_q && (rx_len_q == ERI_OVERSIZE_BYTES);
  end

  always_ff @(posedge CLK_SYS_I)
  begin
    if (!RESETN_I)
    begin
      sa7_tgl_prev_q <= 1'b0;
      sa7_hist_q     <= 3'h7;
      sa7_zero_q     <= 1'b0;
      zr_prev_q      <= 1'b0;
    end
    else if (CE_I)
    begin
      sa7_tgl_prev_q <= sa7_tgl_s;
      if (sa7_obs)
      begin
        sa7_hist_q <= {sa7_hist_q[1:0], sa7_bit_s};
      end
      sa7_zero_q <= sa7_zero_d;
      zr_prev_q  <= zr_s;
    end
  end

  // R7 consecutive bad-frame counter; a good frame restarts it
  always_ff @(posedge CLK_SYS_I)
  begin
    if (!RESETN_I)
    begin
      crc_cnt_q <= 7'h00;
    end
    else if (CE_I && EVT_I.crc_frame_done)
    begin
      if (!EVT_I.crc_frame_bad || crc_hit)
      begin
        crc_cnt_q <= 7'h00;
      end
      else
      begin
        crc_cnt_q <= crc_cnt_q + 7'd1;
      end
    end
  end

  // R8 received length counter, saturating past the limit
  always_ff @(posedge CLK_SYS_I)
  begin
    if (!RESETN_I)
    begin
      rx_len_q  <= 9'h000;
      rx_over_q <= 1'b0;
    end
    else if (CE_I)
    begin
      if (EVT_I.rx_msg_start)
      begin
        rx_len_q  <= 9'h000;
        rx_over_q <= 1'b0;
      end
      else if (EVT_I.rx_byte && !rx_over_q)
      begin
        if (rx_len_q == ERI_OVERSIZE_BYTES)
        begin
          rx_over_q <= 1'b1;
        end
        else
        begin
          rx_len_q <= rx_len_q + 9'd1;
        end
      end
    end
  end

  // R9 R15 sticky flags; a new event wins over clear-on-read
  always_ff @(posedge CLK_SYS_I)
  begin
    if (!RESETN_I)
    begin
      sig_status_q <= ERI_RESET_BYTE;
      zr_status_q  <= ERI_RESET_BYTE;
    end
    else if (CE_I)
    begin
      sig_status_q <= ((rd_sig ? 8'h00 : sig_status_q) | sig_set) & ERI_SIG_MASK;
      zr_status_q  <= ((rd_zr ? 8'h00 : zr_status_q) | zr_set) & ERI_ZR_MASK;
    end
  end

  // R5 R10 R11 R14 enable registers and threshold select
  always_ff @(posedge CLK_SYS_I)
  begin
    if (!RESETN_I)
    begin
      sig_enable_q <= ERI_RESET_BYTE;
      zr_enable_q  <= ERI_RESET_BYTE;
      thresh_hi_q  <= 1'b0;
    end
    else if (CE_I && acc && PWRITE_I)
    begin
      if (PADDR_I == ERI_ADDR_SIG_ENABLE)
      begin
        sig_enable_q <= PWDATA_I[7:0] & ERI_SIG_MASK;
      end
      if (PADDR_I == ERI_ADDR_ZR_ENABLE)
      begin
        zr_enable_q <= PWDATA_I[7:0] & ERI_ZR_MASK;
        thresh_hi_q <= PWDATA_I[7];
      end
    end
  end

  // APB answer, one cycle after the access phase starts, so one wait state
  always_ff @(posedge CLK_SYS_I)
  begin
    if (!RESETN_I)
    begin
      PREADY_O  <= 1'b0;
      PSLVERR_O <= 1'b0;
      PRDATA_O  <= 32'h0000_0000;
    end
    else if (CE_I)
    begin
      PREADY_O  <= acc;
      PSLVERR_O <= acc && !mapped;
      PRDATA_O  <= 32'h0000_0000;
      if (acc && !PWRITE_I)
      begin
        case (PADDR_I)
          ERI_ADDR_SIG_STATUS: PRDATA_O <= {24'h00_0000, sig_status_q};
          ERI_ADDR_SIG_ENABLE: PRDATA_O <= {24'h00_0000, sig_enable_q};
          ERI_ADDR_ZR_ENABLE:  PRDATA_O <= {24'h00_0000, thresh_hi_q, zr_enable_q[6:0]};
          ERI_ADDR_ZR_STATUS:  PRDATA_O <= {24'h00_0000, zr_status_q};
          default:             PRDATA_O <= 32'h0000_0000;
        endcase
      end
    end
  end

  // R16 interrupt from flags gated by enables
  always_ff @(posedge CLK_SYS_I)
  begin
    if (!RESETN_I)
    begin
      IRQ_O      <= 1'b0;
      SA7_ZERO_O <= 1'b0;
    end
    else if (CE_I)
    begin
      IRQ_O      <= |(sig_status_q & sig_enable_q) || |(zr_status_q & zr_enable_q);
      SA7_ZERO_O <= sa7_zero_q;
    end
  end

  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RESETN_I);

  sequence s_sa7_rise;
    CE_I && sa7_zero_d && !sa7_zero_q;
  endsequence

  chk_sa7_decl_flag: assert property (s_sa7_rise |=> zr_status_q[ERI_BIT_SA7]) // R1
    else $error("Sa7 declaration did not set flag");
  chk_sa7_end_flag: assert property (CE_I && !sa7_zero_d && sa7_zero_q
                                     |=> zr_status_q[ERI_BIT_SA7]) // R2
    else $error("Sa7 release did not set flag");
  chk_zr_rise_flag: assert property (CE_I && zr_s && !zr_prev_q
                                     |=> zr_status_q[ERI_BIT_ZERO_RUN]) // R3
    else $error("Zero-run declare missed");
  chk_zr_fall_flag: assert property (CE_I && !zr_s && zr_prev_q
                                     |=> zr_status_q[ERI_BIT_ZERO_RUN]) // R4
    else $error("Zero-run removal missed");
  chk_en_blocks_irq: assert property (CE_I && zr_enable_q == 8'h00 && sig_enable_q == 8'h00
                                      |=> !IRQ_O) // R5
    else $error("Interrupt with all enables clear");
  chk_crc_fail_set: assert property (CE_I && crc_hit
                                     |=> sig_status_q[ERI_BIT_CRC_FAIL]) // R6
    else $error("Failure flag not set");
  chk_crc_thresh: assert property (crc_hit |-> (crc_cnt_q == ERI_CRC_THRESH_LO - 7'd1 // R7
                                              || crc_cnt_q == ERI_CRC_THRESH_HI - 7'd1))
    else $error("Threshold count wrong");
  chk_oversize_len: assert property (sig_set[ERI_BIT_OVERSIZE] // R8
                                     |-> rx_len_q == ERI_OVERSIZE_BYTES)
    else $error("Oversize at wrong length");
  chk_read_clears: assert property (CE_I && rd_sig && sig_set == 8'h00
                                    |=> sig_status_q == 8'h00) // R9
    else $error("Read did not clear status");
  chk_set_wins: assert property (CE_I && rd_zr && zr_set[ERI_BIT_ZERO_RUN]
                                 |=> zr_status_q[ERI_BIT_ZERO_RUN]) // R15
    else $error("Event lost on read");
  chk_irq_level: assert property (CE_I && |(sig_status_q & sig_enable_q)
                                  |=> IRQ_O) // R16
    else $error("Interrupt not raised");
  chk_apb_answer: assert property (CE_I && acc |=> PREADY_O ##1 (!PREADY_O || !CE_I)) // APB port
    else $error("APB answer timing wrong");
  // A read and an event in one cycle: the event must survive the clear
  chk_sig_read_set: assert property (CE_I && rd_sig // R9
                                     |=> sig_status_q == ($past(sig_set) & ERI_SIG_MASK))
    else $error("Status after read wrong");
  chk_ce_freeze: assert property (!CE_I |=> $stable(sig_status_q) && $stable(zr_status_q) // R9
                                  && $stable(crc_cnt_q))
    else $error("State moved while clock enable low");
  chk_tx_start_flag: assert property (CE_I && EVT_I.tx_unit_start // R12
                                      |=> sig_status_q[ERI_BIT_TX_START])
    else $error("Tx start flag not set");
  chk_rx_end_flag: assert property (CE_I && EVT_I.rx_msg_end // R13
                                    |=> sig_status_q[ERI_BIT_RX_END])
    else $error("Rx end flag not set");
  chk_sig_en_write: assert property (CE_I && acc && PWRITE_I // R14
                                     && PADDR_I == ERI_ADDR_SIG_ENABLE
                                     |=> sig_enable_q == ($past(PWDATA_I[7:0]) & ERI_SIG_MASK))
    else $error("Signalling enable write lost");
  chk_zr_en_write: assert property (CE_I && acc && PWRITE_I // R5 R7
                                    && PADDR_I == ERI_ADDR_ZR_ENABLE
                                    |=> zr_enable_q == ($past(PWDATA_I[7:0]) & ERI_ZR_MASK)
                                    && thresh_hi_q == $past(PWDATA_I[7]))
    else $error("Zero-run enable write lost");
  chk_zr_irq_level: assert property (CE_I && |(zr_status_q & zr_enable_q) |=> IRQ_O) // R16
    else $error("Zero-run interrupt not raised");
  chk_irq_drop: assert property (CE_I && !(|(sig_status_q & sig_enable_q)) // R16
                                 && !(|(zr_status_q & zr_enable_q)) |=> !IRQ_O)
    else $error("Interrupt held with no enabled flag");

endmodule // eri_irq
`default_nettype wire

// *** verilog/eri_pkg.sv ***
// Package: register map, field positions and carriers for the signalling/zero-run interrupt block
package eri_pkg;

  // Register indices; the APB byte address is index * 4
  localparam logic [15:0] ERI_IDX_SIG_STATUS = 16'h0B10;
  localparam logic [15:0] ERI_IDX_SIG_ENABLE = 16'h0B11;
  localparam logic [15:0] ERI_IDX_ZR_ENABLE  = 16'h0B12;
  localparam logic [15:0] ERI_IDX_ZR_STATUS  = 16'h0B13;
  localparam logic [17:0] ERI_ADDR_SIG_STATUS = {ERI_IDX_SIG_STATUS, 2'b00};
  localparam logic [17:0] ERI_ADDR_SIG_ENABLE = {ERI_IDX_SIG_ENABLE, 2'b00};
  localparam logic [17:0] ERI_ADDR_ZR_ENABLE  = {ERI_IDX_ZR_ENABLE, 2'b00};
  localparam logic [17:0] ERI_ADDR_ZR_STATUS  = {ERI_IDX_ZR_STATUS, 2'b00};

  // Signalling status / enable bit positions
  localparam int ERI_BIT_TX_START  = 5;
  localparam int ERI_BIT_RX_START  = 4;
  localparam int ERI_BIT_TX_END    = 3;
  localparam int ERI_BIT_RX_END    = 2;
  localparam int ERI_BIT_CRC_FAIL  = 1;
  localparam int ERI_BIT_OVERSIZE  = 0;
  // Zero-run status / enable bit positions
  localparam int ERI_BIT_SA7       = 1;
  localparam int ERI_BIT_ZERO_RUN  = 0;

  localparam logic [7:0] ERI_SIG_MASK   = 8'h3F;
  localparam logic [7:0] ERI_ZR_MASK    = 8'h03;
  localparam logic [7:0] ERI_RESET_BYTE = 8'h00;

  // Failure thresholds in consecutive bad-CRC frames, oversize limit in bytes
  localparam logic [6:0] ERI_CRC_THRESH_LO  = 7'd32;
  localparam logic [6:0] ERI_CRC_THRESH_HI  = 7'd64;
  localparam logic [8:0] ERI_OVERSIZE_BYTES = 9'd276;

  // Sa7 vote: zero in at least VOTE_MIN of VOTE_LEN observations
  localparam int ERI_VOTE_LEN = 3;
  localparam int ERI_VOTE_MIN = 2;

  // Event pulses from the framer and signalling engine
  typedef struct packed {
    logic sa7_obs_valid;
    logic sa7_obs_bit;
    logic zero_run_state;
    logic crc_frame_done;
    logic crc_frame_bad;
    logic rx_byte;
    logic rx_msg_end;
    logic tx_unit_start;
    logic tx_unit_end;
    logic rx_msg_start;
  } eri_event_type;

endpackage : eri_pkg

// *** verilog/eri_sync.sv ***
// Three-stage synchroniser for an input from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module eri_sync
  import eri_pkg::*;
(
  input  wire logic clk_i,    // System clock
  input  wire logic rst_n_i,  // Synchronous reset, active low
  input  wire logic ce_i,     // Clock enable
  input  wire logic d_i,      // Asynchronous level
  output logic      q_o       // Accepted level
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      q_o  <= 1'b0;
    end
    else if (ce_i)
    begin
      s1_q <= d_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // Change accepted only once stages two and three agree
      if (s2_q == s3_q)
      begin
        q_o <= s3_q;
      end
    end
  end
endmodule // eri_sync
`default_nettype wire
